// file: rtl/sphy_pkg.sv
// constants for the serial phy lane and status port block
package sphy_pkg;
    localparam int LANE_COUNT = 4;
    localparam int BYTES_PER_LANE = 4;
    localparam int TXW = 32 * LANE_COUNT;
    localparam int KW = BYTES_PER_LANE * LANE_COUNT;
    localparam int HADDR_W = 12;
    // register byte offsets
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_STATUS = 12'h004;
    localparam logic [11:0] OFS_TIMEOUT = 12'h008;
    localparam logic [11:0] OFS_GENCTL = 12'h00C;
    localparam logic [11:0] OFS_ERRSTAT = 12'h010;
    localparam logic [11:0] OFS_RXERR = 12'h014;
    // control register fields
    localparam int CTRL_INHIBIT_LSB = 0;
    localparam int CTRL_BOND_EN = 4;
    localparam int CTRL_SIM_TRAIN = 5;
    localparam int CTRL_IDLE2 = 6;
    localparam int CTRL_MAINT_ONLY = 7;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0010;
    // general control fields
    localparam int GEN_HOST = 31;
    // port error and status fields
    localparam int ES_UNINIT = 0;
    localparam int ES_PORT_ERR = 2;
    localparam logic [23:0] TIMEOUT_RESET = 24'hFFFFFF;
    // symbol counts for link initialization and for received link reset detection
    localparam logic [4:0] TX_STATUS_NEED = 5'd15;
    localparam logic [3:0] RX_STATUS_NEED = 4'd8;
    localparam logic [2:0] LINK_RESET_NEED = 3'd4;
    // initialization silence time
    localparam int SILENCE_US = 12;
    localparam int SILENCE_SIM_NS = 200;
    localparam int CLK_NS = 10;
    localparam int SILENCE_CYC = SILENCE_US * 1000 / CLK_NS;
    localparam int SILENCE_SIM_CYC = SILENCE_SIM_NS / CLK_NS;
    // control characters
    localparam logic [7:0] K_COMMA = 8'hBC;
    localparam logic [7:0] K_SC = 8'h1C;
    localparam logic [7:0] K_IDLE = 8'hFD;
    localparam logic [7:0] ST_STATUS = 8'h04;
    localparam logic [7:0] ST_LINK_RESET = 8'h03;
    localparam logic [7:0] ST_MCE = 8'h0C;
    typedef enum logic [4:0] {
        INIT_RESET = 5'b00001,
        INIT_WAIT_DONE = 5'b00010,
        INIT_SILENT = 5'b00100,
        INIT_TRAIN = 5'b01000,
        INIT_OK = 5'b10000
    } sphy_init_t;
endpackage

// file: rtl/sphy_lane_rx.sv
// receive symbol decoder for one lane word
`timescale 1ns/1ps
`default_nettype none
module sphy_lane_rx
    import sphy_pkg::*;
(
    input wire logic [31:0] rx_word,
    input wire logic [3:0] rx_isk,
    input wire logic [3:0] rx_disperr,
    input wire logic [3:0] rx_notintable,
    output logic sym_valid,
    output logic sym_err,
    output logic [7:0] sym_type
);
    // symbol: K_SC in byte 0, type in byte 1
    always_comb begin
        sym_valid = rx_isk[0] && rx_word[7:0] == K_SC;
        sym_err = |(rx_disperr | rx_notintable);
        sym_type = rx_word[15:8];
    end
endmodule
`default_nettype wire

// file: rtl/sphy_top.sv
// serial phy lane, status ports and register slave
//
// The register addresses and the AHB-Lite register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module sphy_top
    import sphy_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [sphy_pkg::HADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic serial_side_clock,
    output logic [sphy_pkg::TXW-1:0] tx_data,
    output logic [sphy_pkg::KW-1:0] tx_isk,
    output logic [sphy_pkg::LANE_COUNT-1:0] tx_inhibit,
    input wire logic [sphy_pkg::TXW-1:0] rx_data,
    input wire logic [sphy_pkg::KW-1:0] rx_isk,
    input wire logic [sphy_pkg::KW-1:0] rx_iscomma,
    input wire logic [sphy_pkg::KW-1:0] rx_disperr,
    input wire logic [sphy_pkg::KW-1:0] rx_notintable,
    input wire logic [sphy_pkg::LANE_COUNT-1:0] rx_bondseq,
    input wire logic [sphy_pkg::LANE_COUNT-1:0] rx_aligned,
    output logic bond_enable,
    input wire logic xcvr_reset_req,
    output logic xcvr_reset,
    input wire logic [sphy_pkg::LANE_COUNT-1:0] xcvr_reset_done,
    input wire logic sim_train_en,
    input wire logic mce_req,
    input wire logic link_reset_req,
    input wire logic force_reinit,
    output logic link_initialized,
    output logic rcvd_mce,
    output logic rcvd_link_reset,
    output logic port_error,
    output logic port_initialized,
    output logic single_lane_trained,
    output logic redundancy_lane,
    output logic idle_selected,
    output logic [23:0] port_timeout,
    output logic host_bit,
    output logic maint_only
);
    logic [31:0] ctrl_q;
    logic [23:0] timeout_q;
    logic host_q;
    logic [2:0] errstat_q;
    logic [15:0] rxerr_q;
    logic wr_pend_q;
    logic [11:0] wr_addr_q;
    logic [11:0] rd_addr_q;
    logic rd_pend_q;
    sphy_init_t state_q;
    logic [31:0] tmr_q;
    logic [4:0] tx_stat_q;
    logic [3:0] rx_stat_q;
    logic [2:0] lr_cnt_q;
    logic mce_pend_q;
    logic mce_rx_q;
    logic [2:0] clk_sync_q;
    logic [KW-1:0] isk_s1_q, isk_s2_q, disp_s1_q, disp_s2_q, nit_s1_q, nit_s2_q;
    logic [TXW-1:0] data_s1_q, data_s2_q;
    logic [LANE_COUNT-1:0] bseq_s1_q, bseq_s2_q, algn_s1_q, algn_s2_q;
    logic [LANE_COUNT-1:0] done_s1_q, done_s2_q;
    logic req_s1_q, req_s2_q;
    logic pcs_tick;
    logic sym_valid, sym_err;
    logic [7:0] sym_type;
    logic all_aligned;

    function automatic logic [31:0] lane_sym(input logic [7:0] stype);
        lane_sym = {8'h00, 8'h00, stype, K_SC};
    endfunction

    // ---------------- bus slave ----------------
    wire take = hsel && hready && htrans[1];
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            wr_addr_q <= 12'h000;
            rd_addr_q <= 12'h000;
        end else begin
            wr_pend_q <= take && hwrite;
            rd_pend_q <= take && !hwrite;
            if (take) begin
                wr_addr_q <= haddr;
                rd_addr_q <= haddr;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q <= CTRL_RESET;
            timeout_q <= TIMEOUT_RESET;
            host_q <= 1'b0;
        end else if (wr_pend_q) begin
            case (wr_addr_q)
                OFS_CTRL: ctrl_q <= hwdata;
                OFS_TIMEOUT: timeout_q <= hwdata[23:0];
                OFS_GENCTL: host_q <= hwdata[GEN_HOST];
                default: ;
            endcase
        end
    end

    always_comb begin
        case (rd_addr_q)
            OFS_CTRL: hrdata = ctrl_q;
            OFS_STATUS: hrdata = {12'h000, bseq_s2_q, algn_s2_q, state_q, single_lane_trained, redundancy_lane,
                link_initialized, rcvd_link_reset, xcvr_reset, rcvd_mce, port_error};
            OFS_TIMEOUT: hrdata = {8'h00, timeout_q};
            OFS_GENCTL: hrdata = {host_q, 31'h0};
            OFS_ERRSTAT: hrdata = {29'h0, errstat_q};
            OFS_RXERR: hrdata = {16'h0, rxerr_q};
            default: hrdata = 32'h0000_0000;
        endcase
    end

    // ---------------- synchronisers ----------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clk_sync_q <= 3'b000;
            isk_s1_q <= '0;
            isk_s2_q <= '0;
            disp_s1_q <= '0;
            disp_s2_q <= '0;
            nit_s1_q <= '0;
            nit_s2_q <= '0;
            data_s1_q <= '0;
            data_s2_q <= '0;
            bseq_s1_q <= '0;
            bseq_s2_q <= '0;
            algn_s1_q <= '0;
            algn_s2_q <= '0;
            done_s1_q <= '0;
            done_s2_q <= '0;
            req_s1_q <= 1'b0;
            req_s2_q <= 1'b0;
        end else begin
            clk_sync_q <= {clk_sync_q[1:0], serial_side_clock};
            isk_s1_q <= rx_isk;
            isk_s2_q <= isk_s1_q;
            disp_s1_q <= rx_disperr;
            disp_s2_q <= disp_s1_q;
            nit_s1_q <= rx_notintable;
            nit_s2_q <= nit_s1_q;
            data_s1_q <= rx_data;
            data_s2_q <= data_s1_q;
            bseq_s1_q <= rx_bondseq;
            bseq_s2_q <= bseq_s1_q;
            algn_s1_q <= rx_aligned;
            algn_s2_q <= algn_s1_q;
            done_s1_q <= xcvr_reset_done;
            done_s2_q <= done_s1_q;
            req_s1_q <= xcvr_reset_req;
            req_s2_q <= req_s1_q;
        end
    end
    // rising edge of the sampled serial-side clock marks one word slot
    assign pcs_tick = clk_sync_q[1] && !clk_sync_q[2];
    assign all_aligned = &algn_s2_q;

    // lane 0 carries the symbol stream; other lanes copy it
    sphy_lane_rx u_rx0 (
        .rx_word(data_s2_q[31:0]),
        .rx_isk(isk_s2_q[3:0]),
        .rx_disperr(disp_s2_q[3:0]),
        .rx_notintable(nit_s2_q[3:0]),
        .sym_valid(sym_valid),
        .sym_err(sym_err),
        .sym_type(sym_type)
    );

    // ---------------- initialization ----------------
    wire [31:0] silence_len = sim_train_en ? 32'(SILENCE_SIM_CYC) : 32'(SILENCE_CYC);
    wire clean_status = pcs_tick && sym_valid && !sym_err && sym_type == ST_STATUS;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= INIT_RESET;
            tmr_q <= 32'h0;
            tx_stat_q <= 5'd0;
            rx_stat_q <= 4'd0;
        end else begin
            case (state_q)
                INIT_RESET: state_q <= INIT_WAIT_DONE;
                INIT_WAIT_DONE: begin
                    if (&done_s2_q) begin
                        state_q <= INIT_SILENT;
                        tmr_q <= 32'h0;
                    end
                end
                INIT_SILENT: begin
                    tmr_q <= tmr_q + 32'h1;
                    if (tmr_q >= silence_len) begin
                        state_q <= INIT_TRAIN;
                        tx_stat_q <= 5'd0;
                        rx_stat_q <= 4'd0;
                    end
                end
                INIT_TRAIN: begin
                    if (pcs_tick && tx_stat_q != TX_STATUS_NEED) begin
                        tx_stat_q <= tx_stat_q + 5'd1;
                    end
                    if (pcs_tick && sym_valid && sym_err) begin
                        rx_stat_q <= 4'd0;
                    end else if (clean_status && rx_stat_q != RX_STATUS_NEED) begin
                        rx_stat_q <= rx_stat_q + 4'd1;
                    end
                    if (tx_stat_q == TX_STATUS_NEED && rx_stat_q == RX_STATUS_NEED) begin
                        state_q <= INIT_OK;
                    end
                end
                INIT_OK: ;
                default: state_q <= INIT_RESET;
            endcase
            // reset request restarts via transceiver reset
            if (req_s2_q) begin
                state_q <= INIT_RESET;
            end else if (force_reinit && state_q != INIT_RESET && state_q != INIT_WAIT_DONE) begin
                state_q <= INIT_SILENT;
                tmr_q <= 32'h0;
            end
        end
    end

    assign xcvr_reset = state_q == INIT_RESET || state_q == INIT_WAIT_DONE;
    assign link_initialized = state_q == INIT_OK;

    // ---------------- transmit ----------------
    // one pending multicast, sent on next slot without a link reset request
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mce_pend_q <= 1'b0;
        end else if (mce_req) begin
            mce_pend_q <= 1'b1;
        end else if (pcs_tick && !link_reset_req) begin
            mce_pend_q <= 1'b0;
        end
    end

    // data and K flags per lane
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_data <= '0;
            tx_isk <= '0;
        end else if (pcs_tick) begin
            for (int l = 0; l < LANE_COUNT; l++) begin
                if (link_reset_req) begin
                    tx_data[32*l +: 32] <= lane_sym(ST_LINK_RESET);
                    tx_isk[4*l +: 4] <= 4'b0001;
                end else if (mce_pend_q) begin
                    tx_data[32*l +: 32] <= lane_sym(ST_MCE);
                    tx_isk[4*l +: 4] <= 4'b0001;
                end else if (state_q == INIT_TRAIN) begin
                    tx_data[32*l +: 32] <= lane_sym(ST_STATUS);
                    tx_isk[4*l +: 4] <= 4'b0001;
                end else begin
                    tx_data[32*l +: 32] <= {K_IDLE, K_IDLE, K_IDLE, K_COMMA};
                    tx_isk[4*l +: 4] <= 4'b1111;
                end
            end
        end
    end

    // inhibit per lane, forced during silence
    always_comb begin
        tx_inhibit = ctrl_q[CTRL_INHIBIT_LSB +: LANE_COUNT];
        if (state_q == INIT_SILENT) begin
            tx_inhibit = '1;
        end
    end
    assign bond_enable = ctrl_q[CTRL_BOND_EN];

    // ---------------- receive ----------------
    // count link resets, skip status and idles
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lr_cnt_q <= 3'd0;
        end else if (pcs_tick) begin
            if (sym_err) begin
                lr_cnt_q <= 3'd0;
            end else if (sym_valid && sym_type == ST_LINK_RESET) begin
                if (lr_cnt_q != LINK_RESET_NEED) begin
                    lr_cnt_q <= lr_cnt_q + 3'd1;
                end
            end else if (sym_valid && sym_type != ST_STATUS) begin
                lr_cnt_q <= 3'd0;
            end
        end
    end
    assign rcvd_link_reset = lr_cnt_q == LINK_RESET_NEED;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mce_rx_q <= 1'b0;
        end else begin
            mce_rx_q <= pcs_tick && sym_valid && !sym_err && sym_type == ST_MCE;
        end
    end
    assign rcvd_mce = mce_rx_q;

    // sticky per-byte errors, event wins over clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rxerr_q <= 16'h0;
            errstat_q <= 3'b001;
        end else begin
            if (wr_pend_q && wr_addr_q == OFS_RXERR) begin
                rxerr_q <= (rxerr_q & ~hwdata[15:0]) | (disp_s2_q | nit_s2_q);
            end else begin
                rxerr_q <= rxerr_q | disp_s2_q | nit_s2_q;
            end
            // error on lost alignment after init
            errstat_q[ES_UNINIT] <= !link_initialized;
            if (link_initialized && !all_aligned) begin
                errstat_q[ES_PORT_ERR] <= 1'b1;
            end else if (wr_pend_q && wr_addr_q == OFS_ERRSTAT && hwdata[ES_PORT_ERR]) begin
                errstat_q[ES_PORT_ERR] <= 1'b0;
            end
            errstat_q[1] <= 1'b0;
        end
    end
    assign port_error = errstat_q[ES_PORT_ERR];
    assign port_initialized = !errstat_q[ES_UNINIT];
    assign single_lane_trained = link_initialized && !all_aligned && algn_s2_q[0];
    assign redundancy_lane = link_initialized && !all_aligned && !algn_s2_q[0] && algn_s2_q[2];
    assign idle_selected = state_q == INIT_TRAIN || link_initialized;
    assign port_timeout = timeout_q;
    assign host_bit = host_q;
    assign maint_only = ctrl_q[CTRL_MAINT_ONLY];

    property p_init_counts;
        @(posedge hclk) disable iff (!hresetn)
        $rose(link_initialized) |-> $past(tx_stat_q) == 5'd15 && $past(rx_stat_q) == 4'd8;
    endproperty
    a_init_counts: assert property (p_init_counts) else $error("init without counts");

    property p_lr_hold;
        @(posedge hclk) disable iff (!hresetn)
        link_reset_req && pcs_tick ##1 1'b1 |-> tx_data[15:8] == ST_LINK_RESET;
    endproperty
    a_lr_hold: assert property (p_lr_hold) else $error("link reset not sent");

    property p_xrst;
        @(posedge hclk) disable iff (!hresetn)
        xcvr_reset && !(&done_s2_q) |=> xcvr_reset;
    endproperty
    a_xrst: assert property (p_xrst) else $error("reset released early");

    property p_req;
        @(posedge hclk) disable iff (!hresetn)
        req_s2_q |=> xcvr_reset;
    endproperty
    a_req: assert property (p_req) else $error("reset request ignored");

    property p_rlr;
        @(posedge hclk) disable iff (!hresetn)
        pcs_tick && sym_err |=> !rcvd_link_reset;
    endproperty
    a_rlr: assert property (p_rlr) else $error("link reset kept after error");

    property p_mce;
        @(posedge hclk) disable iff (!hresetn)
        mce_req && !link_reset_req |-> ##[1:20] (tx_data[15:8] == ST_MCE);
    endproperty
    a_mce: assert property (p_mce) else $error("mce not sent");

    property p_tmo;
        @(posedge hclk) disable iff (!hresetn)
        $changed(port_timeout) |-> $past(wr_pend_q);
    endproperty
    a_tmo: assert property (p_tmo) else $error("timeout changed alone");

    property p_perr;
        @(posedge hclk) disable iff (!hresetn)
        link_initialized && !all_aligned |=> port_error;
    endproperty
    a_perr: assert property (p_perr) else $error("port error not raised");
endmodule
`default_nettype wire

// file: tb/sphy_xcvr_model.sv
// transceiver partner model for the serial phy block
`timescale 1ns/1ps
`default_nettype none
module sphy_xcvr_model
    import sphy_pkg::*;
(
    output logic serial_side_clock,
    output logic [sphy_pkg::TXW-1:0] rx_data,
    output logic [sphy_pkg::KW-1:0] rx_isk,
    output logic [sphy_pkg::KW-1:0] rx_iscomma,
    output logic [sphy_pkg::KW-1:0] rx_disperr,
    output logic [sphy_pkg::KW-1:0] rx_notintable,
    output logic [sphy_pkg::LANE_COUNT-1:0] rx_bondseq,
    output logic [sphy_pkg::LANE_COUNT-1:0] rx_aligned,
    output logic xcvr_reset_req,
    input wire logic xcvr_reset,
    output logic [sphy_pkg::LANE_COUNT-1:0] xcvr_reset_done,
    input wire logic [2:0] sym_sel,
    input wire logic want_reset
);
    logic [31:0] word;
    logic [3:0] k;
    int rst_cnt = 0;
    initial begin
        serial_side_clock = 1'b0;
        forever #40 serial_side_clock = ~serial_side_clock;
    end
    // sel: 0 idle, 1 status, 2 link reset, 3 multicast, 4 status with bad disparity
    // sel 5 and 6: status with only lane 0 or only lane 2 aligned
    always_comb begin
        k = 4'h1;
        word = {16'h0000, ST_STATUS, K_SC};
        if (sym_sel == 3'd2) word = {16'h0000, ST_LINK_RESET, K_SC};
        if (sym_sel == 3'd3) word = {16'h0000, ST_MCE, K_SC};
        if (sym_sel == 3'd0) begin
            word = {K_IDLE, K_IDLE, K_IDLE, K_COMMA};
            k = 4'hF;
        end
    end
    // per-byte flags, same word on every lane
    always @(posedge serial_side_clock) begin
        rx_data <= {LANE_COUNT{word}};
        rx_isk <= {LANE_COUNT{k}};
        rx_iscomma <= {LANE_COUNT{3'b000, sym_sel == 3'd0}};
        rx_disperr <= {LANE_COUNT{3'b000, sym_sel == 3'd4}};
        rx_notintable <= '0;
        rx_bondseq <= {LANE_COUNT{sym_sel == 3'd0}};
        rx_aligned <= sym_sel == 3'd5 ? 4'b0001 : (sym_sel == 3'd6 ? 4'b0100 : 4'b1111);
    end
    // request until reset seen, done after four slots of reset
    always @(posedge serial_side_clock) begin
        xcvr_reset_req <= want_reset & ~xcvr_reset;
        rst_cnt <= xcvr_reset ? rst_cnt + 1 : 0;
        if (xcvr_reset && rst_cnt == 0) begin
            xcvr_reset_done <= '0;
        end else if (rst_cnt == 4) begin
            xcvr_reset_done <= '1;
        end
    end
endmodule
`default_nettype wire

// file: tb/sphy_top_tb_top.sv
// self-checking bench for the serial phy block
`timescale 1ns/1ps
`default_nettype none
module sphy_top_tb_top;
    import sphy_pkg::*;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, serial_side_clock, bond_enable;
    logic xcvr_reset_req, xcvr_reset, sim_train_en, mce_req, link_reset_req, force_reinit;
    logic link_initialized, rcvd_mce, rcvd_link_reset, port_error, port_initialized;
    logic single_lane_trained, redundancy_lane, idle_selected, host_bit, maint_only, want_reset;
    logic [11:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize, sym_sel;
    logic [31:0] hwdata, hrdata, rd;
    logic [23:0] port_timeout;
    logic [TXW-1:0] tx_data, rx_data;
    logic [KW-1:0] tx_isk, rx_isk, rx_iscomma, rx_disperr, rx_notintable;
    logic [LANE_COUNT-1:0] tx_inhibit, rx_bondseq, rx_aligned, xcvr_reset_done;
    int failures, n_compared;

    sphy_top u_sphy_top (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata, .serial_side_clock, .tx_data, .tx_isk,
        .tx_inhibit, .rx_data, .rx_isk, .rx_iscomma, .rx_disperr, .rx_notintable, .rx_bondseq,
        .rx_aligned, .bond_enable, .xcvr_reset_req, .xcvr_reset, .xcvr_reset_done, .sim_train_en,
        .mce_req, .link_reset_req, .force_reinit, .link_initialized, .rcvd_mce, .rcvd_link_reset,
        .port_error, .port_initialized, .single_lane_trained, .redundancy_lane, .idle_selected,
        .port_timeout, .host_bit, .maint_only);
    sphy_xcvr_model u_sphy_xcvr_model (.serial_side_clock, .rx_data, .rx_isk, .rx_iscomma,
        .rx_disperr, .rx_notintable, .rx_bondseq, .rx_aligned, .xcvr_reset_req, .xcvr_reset,
        .xcvr_reset_done, .sym_sel, .want_reset);

    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("FAIL at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic wait_rdy();
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
    endtask
    // single word transfer, entered just after a rising edge
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= a;
        wait_rdy();
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
    endtask
    task automatic wait_init(input int lim, output int i);
        i = 0;
        while (link_initialized !== 1'b1 && i < lim) begin
            @(posedge hclk);
            i++;
        end
    endtask
    task automatic send(input logic [2:0] s, input int n);
        sym_sel <= s;
        repeat (n) @(posedge serial_side_clock);
        @(posedge hclk);
    endtask
    // counts clock cycles with a flag or symbol type shown, over a window
    task automatic count_hi(input logic kind, output int n);
        n = 0;
        repeat (60) begin
            @(posedge hclk);
            if (kind ? rcvd_mce === 1'b1 : tx_data[15:8] === ST_MCE) n++;
        end
    endtask

    task automatic t_init();
        int i;
        wait_init(400, i);
        chk(link_initialized, 1'b1);
        chk(i >= 120, 1'b1);
        chk({idle_selected, single_lane_trained, redundancy_lane, port_error}, 4'h8);
        sym_sel <= 3'd4;
        force_reinit <= 1'b1;
        @(posedge hclk);
        force_reinit <= 1'b0;
        repeat (10) @(posedge hclk);
        chk(link_initialized, 1'b0);
        repeat (300) @(posedge hclk);
        chk(link_initialized, 1'b0);
        sym_sel <= 3'd1;
        wait_init(400, i);
        chk(link_initialized, 1'b1);
        $display("test init done");
    endtask
    task automatic t_regs();
        bus(1'b0, OFS_CTRL, '0);
        chk(rd, CTRL_RESET);
        chk(bond_enable, 1'b1);
        bus(1'b0, OFS_TIMEOUT, '0);
        chk(rd, {8'h00, TIMEOUT_RESET});
        bus(1'b1, OFS_TIMEOUT, 32'h0012_3456);
        bus(1'b1, OFS_GENCTL, 32'h8000_0000);
        bus(1'b1, OFS_CTRL, 32'h0000_0085);
        bus(1'b0, 12'h020, '0);
        chk(rd, 32'h0);
        chk({port_timeout, host_bit}, {24'h123456, 1'b1});
        chk(tx_inhibit, 4'h5);
        chk({maint_only, bond_enable}, 2'b10);
        bus(1'b1, OFS_CTRL, CTRL_RESET);
        $display("test regs done");
    endtask
    task automatic t_tx();
        int n;
        link_reset_req <= 1'b1;
        repeat (3) @(posedge serial_side_clock);
        repeat (5) @(posedge hclk);
        chk(tx_data[15:0], {ST_LINK_RESET, K_SC});
        chk({tx_data[47:32], tx_isk[7:0]}, {ST_LINK_RESET, K_SC, 8'h11});
        link_reset_req <= 1'b0;
        repeat (20) @(posedge hclk);
        mce_req <= 1'b1;
        @(posedge hclk);
        mce_req <= 1'b0;
        count_hi(1'b0, n);
        chk(n, 8);
        $display("test tx done");
    endtask
    task automatic t_rx();
        int n;
        send(3'd3, 1);
        sym_sel <= 3'd1;
        count_hi(1'b1, n);
        chk(n, 1);
        send(3'd2, 3);
        sym_sel <= 3'd0;
        repeat (10) @(posedge hclk);
        chk(rcvd_link_reset, 1'b0);
        send(3'd1, 1);
        send(3'd2, 1);
        sym_sel <= 3'd1;
        repeat (10) @(posedge hclk);
        chk(rcvd_link_reset, 1'b1);
        $display("test rx done");
    endtask
    // lanes drop out of alignment on an initialized link
    task automatic t_align();
        sym_sel <= 3'd5;
        repeat (20) @(posedge hclk);
        chk({port_error, single_lane_trained, redundancy_lane}, 3'b110);
        chk(port_initialized, 1'b1);
        sym_sel <= 3'd6;
        repeat (20) @(posedge hclk);
        chk({single_lane_trained, redundancy_lane}, 2'b01);
        sym_sel <= 3'd1;
        repeat (20) @(posedge hclk);
        bus(1'b1, OFS_ERRSTAT, 32'h0000_0004);
        bus(1'b0, OFS_ERRSTAT, '0);
        chk({rd, port_error}, 33'h0);
        $display("test align done");
    endtask
    task automatic t_xrst();
        int i;
        sim_train_en <= 1'b0;
        want_reset <= 1'b1;
        i = 0;
        while (xcvr_reset !== 1'b1 && i < 100) begin
            @(posedge hclk);
            i++;
        end
        chk({xcvr_reset, link_initialized}, 2'b10);
        want_reset <= 1'b0;
        i = 0;
        while (xcvr_reset !== 1'b0 && i < 200) begin
            @(posedge hclk);
            i++;
        end
        chk({xcvr_reset_done, i > 24}, 5'h1F);
        // full silence time, no simulation shortcut
        wait_init(2000, i);
        chk(link_initialized, 1'b1);
        chk(i > SILENCE_CYC, 1'b1);
        sim_train_en <= 1'b1;
        $display("test xcvr reset done");
    endtask
    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    initial begin
        failures = 0;
        n_compared = 0;
        {hresetn, hsel, hwrite, mce_req, link_reset_req, force_reinit, want_reset} = '0;
        {haddr, htrans, hwdata} = '0;
        hsize = 3'b010;
        sim_train_en = 1'b1;
        sym_sel = 3'd1;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        t_init();
        t_regs();
        t_tx();
        t_rx();
        t_align();
        t_xrst();
        test_done();
    end
    // whole run needs well under 5000 cycles
    initial begin
        #200000;
        failures++;
        test_done();
    end
endmodule
`default_nettype wire
